// ### src/lspfe_pkg.sv
// Constants, types and register map of the load/store, program and floating-point exception entry block.
// Assumes big-endian bit numbering for architected registers: bit 0 is the MSB of a 32-bit word.
package lspfe_pkg;
   // ----------------------------------------------------------------
   // Register map (AXI4-Lite byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] LSPFE_OFF_ALIGN_CAUSE = 8'h00;
   localparam logic [7:0] LSPFE_OFF_SAVED_RET   = 8'h04;
   localparam logic [7:0] LSPFE_OFF_SAVED_STATE = 8'h08;
   localparam logic [7:0] LSPFE_OFF_MACH_STATE  = 8'h0c;
   localparam logic [7:0] LSPFE_OFF_STATUS      = 8'h10;
   localparam logic [7:0] LSPFE_OFF_VEC_BASE    = 8'h14;

   // ----------------------------------------------------------------
   // machine_state bits, as LSB-0 indices (architected bit n -> 31-n)
   // ----------------------------------------------------------------
   localparam int LSPFE_MS_USER_PRIV  = 17; // bit 14
   localparam int LSPFE_MS_FP_AVAIL   = 13; // bit 18
   localparam int LSPFE_MS_MCHK_EN    = 12; // bit 19
   localparam int LSPFE_MS_FP_MODE0   = 11; // bit 20
   localparam int LSPFE_MS_FP_MODE1   = 8;  // bit 23
   localparam int LSPFE_MS_VEC_SEL    = 6;  // bit 25
   localparam int LSPFE_MS_EXC_ENDIAN = 16; // bit 15
   localparam int LSPFE_MS_ENDIAN     = 0;  // bit 31

   // saved_state_and_cause cause bits, LSB-0 indices
   localparam int LSPFE_SS_FP_EN      = 20; // bit 11
   localparam int LSPFE_SS_PRIV       = 18; // bit 13
   localparam int LSPFE_SS_TRAP       = 17; // bit 14
   localparam int LSPFE_SS_SUBSEQ     = 16; // bit 15

   // alignment_cause_status bits 15..21 -> LSB-0 16..10
   localparam int LSPFE_AC_LSB        = 10;

   localparam logic [31:0] LSPFE_MS_RESET     = 32'h0000_0040;
   localparam logic [31:0] LSPFE_VEC_PROGRAM  = 32'h0000_0700;
   localparam logic [31:0] LSPFE_VEC_FP_UNAV  = 32'h0000_0800;
   localparam logic [31:0] LSPFE_BASE_LOW     = 32'h0000_0000;
   localparam logic [31:0] LSPFE_BASE_HIGH    = 32'hfff0_0000;

   // ----------------------------------------------------------------
   // Alignment code fields
   // ----------------------------------------------------------------
   localparam logic [1:0] LSPFE_AM_IMM   = 2'h0;
   localparam logic [1:0] LSPFE_AM_STR   = 2'h1;
   localparam logic [1:0] LSPFE_AM_REV   = 2'h2;
   localparam logic [1:0] LSPFE_AM_IDX   = 2'h3;

   typedef enum logic [3:0] {
      LSPFE_OP_LWZ   = 4'h0,
      LSPFE_OP_STW   = 4'h2,
      LSPFE_OP_LHZ   = 4'h4,
      LSPFE_OP_LHA   = 4'h5,
      LSPFE_OP_STH   = 4'h6,
      LSPFE_OP_LMW   = 4'h7,
      LSPFE_OP_LFS   = 4'h8,
      LSPFE_OP_LFD   = 4'h9,
      LSPFE_OP_STFS  = 4'ha,
      LSPFE_OP_STFD  = 4'hb,
      LSPFE_OP_LHREV = 4'hc,
      LSPFE_OP_SHREV = 4'he
   } lspfe_op_t;

   // Access class as seen by the load/store unit
   typedef enum logic [2:0] {
      LSPFE_K_IMM    = 3'h0,
      LSPFE_K_IDX    = 3'h1,
      LSPFE_K_STRX   = 3'h2,
      LSPFE_K_STRI   = 3'h3,
      LSPFE_K_REV    = 3'h4,
      LSPFE_K_STCX   = 3'h5,
      LSPFE_K_LWARX  = 3'h6,
      LSPFE_K_LWAUX  = 3'h7
   } lspfe_kind_t;

   typedef enum logic [1:0] {
      LSPFE_S_IDLE = 2'b00,
      LSPFE_S_DONE = 2'b01
   } lspfe_state_t;
endpackage

// ### src/lspfe_align_code.sv
// Builds the seven-bit alignment cause code from a decoded load/store description.
// Assumes the load/store unit has already classified the access.
`timescale 1ns/1ps
module lspfe_align_code
   import lspfe_pkg::*;
(
   input  wire lspfe_kind_t kind,
   input  wire logic [3:0]  opLow,
   input  wire logic        update,
   output logic [6:0]       code
);
   always_comb begin
      case (kind)
         LSPFE_K_IMM:   code = {LSPFE_AM_IMM, update, opLow};        // [RL2] [RL3]
         LSPFE_K_IDX:   code = {LSPFE_AM_IDX, update, opLow};        // [RL4]
         LSPFE_K_STRX:  code = {LSPFE_AM_STR, 1'b0, 2'b10, opLow[1], 1'b0}; // [RL5]
         LSPFE_K_STRI:  code = {LSPFE_AM_STR, 1'b0, 2'b10, opLow[1], 1'b1}; // [RL5]
         LSPFE_K_REV:   code = {LSPFE_AM_REV, 1'b0, opLow};          // [RL6]
         LSPFE_K_STCX:  code = {LSPFE_AM_REV, 1'b0, LSPFE_OP_STW};   // [RL6]
         LSPFE_K_LWARX: code = {LSPFE_AM_IMM, 1'b0, LSPFE_OP_LWZ};   // [RL7]
         LSPFE_K_LWAUX: code = {LSPFE_AM_STR, 1'b1, LSPFE_OP_LHA};   // [RL5]
         default:       code = 7'h00;
      endcase
   end
endmodule

// ### src/lspfe_prog_detect.sv
// Detects program and floating-point unavailable exception causes of the current instruction.
// Assumes the sequencer presents decoded instruction flags for one cycle with instValid.
`timescale 1ns/1ps
module lspfe_prog_detect
   import lspfe_pkg::*;
(
   input  wire logic        instValid,
   input  wire logic [31:0] machState,
   input  wire logic        fpEnabledSummary,
   input  wire logic        isMoveToFpsc,
   input  wire logic        isPrivOp,
   input  wire logic        isMoveToMs,
   input  wire logic        isRfi,
   input  wire logic        isSprMove,
   input  wire logic        sprSupervisor,
   input  wire logic        sprValidInternal,
   input  wire logic        sprExternal,
   input  wire logic        trapHit,
   input  wire logic        isFpInst,
   input  wire logic        isUnimpl,
   input  wire logic        higherPending,
   output logic             fpEnCause,
   output logic             privCause,
   output logic             trapCause,
   output logic             takeProgram,
   output logic             takeFpUnav,
   output logic             takeEmul
);
   logic userMode;
   logic fpeWouldSet;
   logic ok;

   always_comb begin
      userMode    = machState[LSPFE_MS_USER_PRIV];
      ok          = instValid && !higherPending;
      // Only move/rfi paths produce the FP-enabled program cause; FP arithmetic raises no FP-enabled exception here
      fpeWouldSet = (machState[LSPFE_MS_FP_MODE0] | machState[LSPFE_MS_FP_MODE1]) & fpEnabledSummary;
      fpEnCause   = ok && !isUnimpl && (isMoveToFpsc || isMoveToMs || isRfi) && fpeWouldSet; // [RL9] [RL10]
      privCause   = ok && !isUnimpl && userMode &&
                    (isPrivOp ||                                                   // [RL11]
                     (isSprMove && sprSupervisor && (sprValidInternal || sprExternal))); // [RL12]
      trapCause   = ok && !isUnimpl && trapHit;                                    // [RL13]
      takeEmul    = ok && isUnimpl;                                                // [RL14]
      takeFpUnav  = ok && !isUnimpl && isFpInst && !machState[LSPFE_MS_FP_AVAIL]; // [RL20]
      takeProgram = !takeFpUnav && (fpEnCause || privCause || trapCause);          // [RL8]
   end
endmodule

// ### src/lspfe_exception_entry.sv
// Top of the load/store alignment, program and floating-point unavailable exception entry block.
// Assumes the sequencer presents one decoded instruction per valid cycle and honours fetch redirects.
//
// What this block does
// RL1 - On alignment exception, write seven-bit access code into cause status bits 15-21.
// RL2 - Middle code bit marks update forms, e.g. updating word load/store.
// RL3 - Immediate-offset non-update forms use leading 00 and the listed op codes.
// RL4 - Indexed forms use leading 11 with same update bit and op code.
// RL5 - String accesses use 01 0 10xx; indexed updating algebraic word load 01 1 0101.
// RL6 - Byte-reversed accesses use 10 0 1xx0; conditional word store 10 0 0010.
// RL7 - Reserving word load gives all-zero code; handler uses fault address register.
// RL8 - Program exception only without higher priority and with at least one cause.
// RL9 - FP-enabled cause when fp moves or rfi leave mode and summary both set.
// RL10 - FP arithmetic enabled condition raises assist exception, not program exception; this block has no assist output and raises neither.
// RL11 - State moves or rfi in user mode raise privileged program exception.
// RL12 - Supervisor special-register move in user mode to valid internal or external raises privileged.
// RL13 - Any true trap condition raises trap program exception.
// RL14 - Unimplemented or illegal instruction raises software emulation, not program exception.
// RL15 - Program entry loads saved return address with excepting instruction address.
// RL16 - Program entry sets bit 11, 13 or 14 by cause, clears bit 12.
// RL17 - Bit 15 clear when saved address is the causing one, else set.
// RL18 - Entry keeps vector base and machine-check enable, copies exception endian, clears rest.
// RL19 - Program exception resumes fetch at 0x00700 from selected base.
// RL20 - FP instruction with fp unavailable raises fp-unavailable exception absent higher priority.
// RL21 - FP-unavailable entry loads saved return address with causing instruction address.
// RL22 - FP-unavailable exception resumes fetch at 0x00800 from selected base.
// RL23 - Entry copies machine state bits 16-31 into saved state bits 16-31.
// RL24 - Program entry clears saved bits 0-10; fp-unavailable clears bits 0-15.
// RL25 - All saved and state updates occur in the redirect cycle.
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module lspfe_exception_entry
   import lspfe_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Instruction presented by the sequencer
   input  wire logic        instValid,
   input  wire logic [31:0] instAddr,
   input  wire logic        higherPending,
   input  wire logic        fpEnabledSummary,
   input  wire logic        isMoveToFpsc,
   input  wire logic        isPrivOp,
   input  wire logic        isMoveToMs,
   input  wire logic        isRfi,
   input  wire logic        isSprMove,
   input  wire logic        sprSupervisor,
   input  wire logic        sprValidInternal,
   input  wire logic        sprExternal,
   input  wire logic        trapHit,
   input  wire logic        isFpInst,
   input  wire logic        isUnimpl,
   input  wire logic        savedIsNext,
   // Alignment fault from the load/store unit
   input  wire logic        alignFault,
   input  wire lspfe_kind_t alignKind,
   input  wire logic [3:0]  alignOp,
   input  wire logic        alignUpdate,
   // Fetch redirect and side exceptions
   output logic             redirectValid,
   output logic [31:0]      redirectAddr,
   output logic             emulRequest,
   output logic [31:0]      machineStateOut,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] alignCause;
   logic [31:0] savedRet;
   logic [31:0] savedState;
   logic [31:0] machState;
   logic [31:0] vecBaseHigh;
   logic [31:0] entryCount;

   logic [6:0]  alignCode;
   logic        fpEnCause;
   logic        privCause;
   logic        trapCause;
   logic        takeProgram;
   logic        takeFpUnav;
   logic        takeEmul;
   logic        takeEntry;

   function automatic logic [31:0] entryState(input logic [31:0] ms);
      logic [31:0] r;
      r = 32'h0;
      r[LSPFE_MS_VEC_SEL] = ms[LSPFE_MS_VEC_SEL];
      r[LSPFE_MS_MCHK_EN] = ms[LSPFE_MS_MCHK_EN];
      r[LSPFE_MS_ENDIAN]  = ms[LSPFE_MS_EXC_ENDIAN];
      return r;
   endfunction

   function automatic logic [31:0] vectorAddr(input logic ip, input logic [31:0] hi,
                                              input logic [31:0] off);
      return (ip ? hi : LSPFE_BASE_LOW) | off;
   endfunction

   lspfe_align_code u_code (
      .kind   (alignKind),
      .opLow  (alignOp),
      .update (alignUpdate),
      .code   (alignCode)
   );

   lspfe_prog_detect u_det (
      .instValid        (instValid),
      .machState        (machState),
      .fpEnabledSummary (fpEnabledSummary),
      .isMoveToFpsc     (isMoveToFpsc),
      .isPrivOp         (isPrivOp),
      .isMoveToMs       (isMoveToMs),
      .isRfi            (isRfi),
      .isSprMove        (isSprMove),
      .sprSupervisor    (sprSupervisor),
      .sprValidInternal (sprValidInternal),
      .sprExternal      (sprExternal),
      .trapHit          (trapHit),
      .isFpInst         (isFpInst),
      .isUnimpl         (isUnimpl),
      .higherPending    (higherPending),
      .fpEnCause        (fpEnCause),
      .privCause        (privCause),
      .trapCause        (trapCause),
      .takeProgram      (takeProgram),
      .takeFpUnav       (takeFpUnav),
      .takeEmul         (takeEmul)
   );

   assign takeEntry = takeProgram || takeFpUnav;

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   logic        awHeld;
   logic        wHeld;
   logic [7:0]  awAddr;
   logic [31:0] wData;
   logic [3:0]  wStrb;
   logic        doWrite;

   assign doWrite = awHeld && wHeld && !s_axi_bvalid;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         awHeld        <= 1'b0;
         wHeld         <= 1'b0;
         awAddr        <= 8'h00;
         wData         <= 32'h0;
         wStrb         <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         s_axi_awready <= !awHeld && !s_axi_awready;
         s_axi_wready  <= !wHeld && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr > LSPFE_OFF_VEC_BASE || awAddr[1:0] != 2'h0 ||
                             awAddr == LSPFE_OFF_STATUS) ? 2'h2 : 2'h0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Architected state; hardware entry wins over a software write
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         alignCause <= 32'h0;
      end else if (alignFault) begin
         alignCause <= 32'h0;
         alignCause[LSPFE_AC_LSB +: 7] <= alignCode;             // [RL1]
      end else if (doWrite && awAddr == LSPFE_OFF_ALIGN_CAUSE) begin
         alignCause <= merge(alignCause, wData, wStrb);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         savedRet   <= 32'h0;
         savedState <= 32'h0;
         machState  <= LSPFE_MS_RESET;
      end else if (takeEntry) begin
         savedRet <= instAddr;                                   // [RL15] [RL21] [RL25]
         savedState <= {16'h0, machState[15:0]};                 // [RL23] [RL24]
         if (takeProgram) begin
            // Priority keeps one cause bit only
            savedState[LSPFE_SS_FP_EN]  <= fpEnCause;            // [RL16]
            savedState[LSPFE_SS_PRIV]   <= !fpEnCause && privCause;
            savedState[LSPFE_SS_TRAP]   <= !fpEnCause && !privCause && trapCause;
            savedState[LSPFE_SS_SUBSEQ] <= savedIsNext;          // [RL17]
         end
         machState <= entryState(machState);                     // [RL18]
      end else if (doWrite) begin
         if (awAddr == LSPFE_OFF_SAVED_RET) begin
            savedRet <= merge(savedRet, wData, wStrb);
         end
         if (awAddr == LSPFE_OFF_SAVED_STATE) begin
            savedState <= merge(savedState, wData, wStrb);
         end
         if (awAddr == LSPFE_OFF_MACH_STATE) begin
            machState <= merge(machState, wData, wStrb);
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         vecBaseHigh <= LSPFE_BASE_HIGH;
      end else if (doWrite && awAddr == LSPFE_OFF_VEC_BASE) begin
         vecBaseHigh <= merge(vecBaseHigh, wData, wStrb);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         entryCount <= 32'h0;
      end else if (takeEntry) begin
         entryCount <= entryCount + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // Fetch redirect
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         redirectValid   <= 1'b0;
         redirectAddr    <= 32'h0;
         emulRequest     <= 1'b0;
      end else begin
         redirectValid <= takeEntry;                             // [RL25]
         emulRequest   <= takeEmul;                              // [RL14]
         if (takeProgram) begin
            redirectAddr <= vectorAddr(machState[LSPFE_MS_VEC_SEL], vecBaseHigh, LSPFE_VEC_PROGRAM); // [RL19]
         end else if (takeFpUnav) begin
            redirectAddr <= vectorAddr(machState[LSPFE_MS_VEC_SEL], vecBaseHigh, LSPFE_VEC_FP_UNAV); // [RL22]
         end
      end
   end

   assign machineStateOut = machState;

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr)
               LSPFE_OFF_ALIGN_CAUSE: s_axi_rdata <= alignCause;
               LSPFE_OFF_SAVED_RET:   s_axi_rdata <= savedRet;
               LSPFE_OFF_SAVED_STATE: s_axi_rdata <= savedState;
               LSPFE_OFF_MACH_STATE:  s_axi_rdata <= machState;
               LSPFE_OFF_STATUS:      s_axi_rdata <= entryCount;
               LSPFE_OFF_VEC_BASE:    s_axi_rdata <= vecBaseHigh;
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_ALIGN_CODE: assert property (@(posedge clk) disable iff (sys_rst) // [RL1]
      alignFault |=> alignCause[16:10] == $past(alignCode))
      else $error("alignment code not captured");
   AST_LWARX_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // [RL7]
      alignFault && alignKind == LSPFE_K_LWARX |=> alignCause == 32'h0)
      else $error("reserving load code not zero");
   AST_PROG_VEC: assert property (@(posedge clk) disable iff (sys_rst) // [RL19]
      takeProgram |=> redirectValid && redirectAddr[19:0] == 20'h00700)
      else $error("program vector wrong");
   AST_FPU_VEC: assert property (@(posedge clk) disable iff (sys_rst) // [RL22]
      takeFpUnav |=> redirectValid && redirectAddr[19:0] == 20'h00800)
      else $error("fp unavailable vector wrong");
   AST_SAVED_ADDR: assert property (@(posedge clk) disable iff (sys_rst) // [RL15]
      takeEntry |=> savedRet == $past(instAddr))
      else $error("saved return address wrong");
   AST_ONE_CAUSE: assert property (@(posedge clk) disable iff (sys_rst) // [RL16]
      $past(takeProgram) |-> $onehot({savedState[20], savedState[18], savedState[17]}) && !savedState[19])
      else $error("program cause bits wrong");
   AST_MS_COPY: assert property (@(posedge clk) disable iff (sys_rst) // [RL23]
      takeEntry |=> savedState[15:0] == $past(machState[15:0]) && machState[0] == $past(machState[16]))
      else $error("state copy wrong");
   AST_FPU_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // [RL24]
      takeFpUnav |=> savedState[31:16] == 16'h0)
      else $error("fp unavailable saved bits not cleared");
   AST_PRIV: assert property (@(posedge clk) disable iff (sys_rst) // [RL11]
      instValid && !higherPending && !isUnimpl && isPrivOp && machState[17] && !(isFpInst && !machState[13])
      && !fpEnCause |=> redirectValid && savedState[18])
      else $error("privileged exception missed");
   AST_EMUL: assert property (@(posedge clk) disable iff (sys_rst) // [RL14]
      instValid && isUnimpl && !higherPending |=> emulRequest && !redirectValid)
      else $error("emulation not raised");
endmodule

// ### verif/lspfe_seq_model.sv
// Sequencer model: issues one decoded instruction per go pulse.
// Assumes the bench pulses go for one cycle; flags follow one edge later.
`timescale 1ns/1ps
module lspfe_seq_model (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [1:0]  sel,
   input  wire logic [31:0] addr,
   output logic             instValid,
   output logic [31:0]      instAddr,
   output logic             isPrivOp,
   output logic             isMoveToMs,
   output logic             isFpInst,
   output logic             isUnimpl,
   output logic             trapHit,
   output logic             savedIsNext
);
   // Flags drop with valid and the address scrambles, so nothing stale looks usable
   always_ff @(posedge clk) begin
      instValid <= go;
      instAddr <= go ? addr : ~addr;
      isPrivOp <= go && sel == 2'h0;
      isMoveToMs <= go && sel == 2'h0;
      isFpInst <= go && sel == 2'h1;
      isUnimpl <= go && sel == 2'h2;
      trapHit <= go && sel == 2'h3;
      savedIsNext <= go && sel == 2'h3;
   end
endmodule

// ### verif/lspfe_exception_entry_tb.sv
// Bench: register bus tasks and exception entry sequences.
// Assumes entry shows one edge after the model's instValid.
`timescale 1ns/1ps
module lspfe_exception_entry_tb;
   import lspfe_pkg::*;
   logic clk = 0, sys_rst = 1, go = 0, higherPending = 0, alignFault = 0, alignUpdate = 0;
   logic isMoveToFpsc = 0, isRfi = 0, isSprMove = 0, sprSupervisor = 0, sprValidInternal = 0;
   logic sprExternal = 0, fpEnabledSummary = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [1:0] sel = 0, resp, s_axi_bresp, s_axi_rresp;
   logic [3:0] alignOp = 0, s_axi_wstrb = 4'hf;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] addr = 0, s_axi_wdata = 0, rd, instAddr, redirectAddr, machineStateOut, s_axi_rdata;
   lspfe_kind_t alignKind = LSPFE_K_IMM;
   logic instValid, isPrivOp, isMoveToMs, isFpInst, isUnimpl, trapHit, savedIsNext, redirectValid;
   logic emulRequest, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   lspfe_kind_t ak[7] = '{LSPFE_K_IMM, LSPFE_K_IDX, LSPFE_K_LWARX, LSPFE_K_STRI, LSPFE_K_LWAUX,
      LSPFE_K_STCX, LSPFE_K_REV};
   logic [3:0] ao[7] = '{4'h0, 4'hb, 4'h0, 4'hb, 4'h5, 4'h2, 4'he};
   logic [6:0] ac[7] = '{7'h10, 7'h7b, 7'h00, 7'h2b, 7'h35, 7'h42, 7'h4e};
   logic [6:0] au = 7'h13;
   int errors = 0, total_checks = 0;
   lspfe_exception_entry dut (.*);
   lspfe_seq_model seq (.clk, .go, .sel, .addr, .instValid, .instAddr, .isPrivOp, .isMoveToMs,
      .isFpInst, .isUnimpl, .trapHit, .savedIsNext);
   initial forever #5 clk = ~clk;
   task automatic chk(input string n, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_awvalid || s_axi_wvalid);
      s_axi_bready <= 1;
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      s_axi_rready <= 1;
      do @(posedge clk); while (!s_axi_rvalid);
      resp = s_axi_rresp;
      s_axi_rready <= 0;
      chk(n, s_axi_rdata, e);
   endtask
   // Redirect and emulation pulses stand one cycle, so they are sampled at that exact edge
   task automatic fire(input logic [1:0] s, input logic [31:0] a, v, m, input logic r, x);
      sel <= s;
      addr <= a;
      go <= 1;
      @(posedge clk);
      go <= 0;
      repeat (2) @(posedge clk);
      chk("redirect", {31'h0, redirectValid}, {31'h0, r});
      chk("emulate", {31'h0, emulRequest}, {31'h0, x});
      chk("vector", redirectAddr, v);
      chk("state", machineStateOut, m);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #20us;
      errors++;
      close_out();
   end
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 0;
      @(posedge clk);
      chk("ms reset", machineStateOut, LSPFE_MS_RESET);
      wr(LSPFE_OFF_MACH_STATE, 32'h0003_0040);
      fire(2'h0, 32'h100, 32'hfff0_0700, 32'h41, 1, 0);
      rchk("ret", LSPFE_OFF_SAVED_RET, 32'h100);
      rchk("saved", LSPFE_OFF_SAVED_STATE, 32'h0004_0040);
      fire(2'h1, 32'h200, 32'hfff0_0800, 32'h40, 1, 0);
      rchk("ret", LSPFE_OFF_SAVED_RET, 32'h200);
      rchk("saved", LSPFE_OFF_SAVED_STATE, 32'h41);
      fire(2'h3, 32'h300, 32'hfff0_0700, 32'h40, 1, 0);
      rchk("saved", LSPFE_OFF_SAVED_STATE, 32'h0003_0040);
      higherPending <= 1;
      fire(2'h3, 32'h400, 32'hfff0_0700, 32'h40, 0, 0);
      higherPending <= 0;
      fire(2'h2, 32'h500, 32'hfff0_0700, 32'h40, 0, 1);
      fpEnabledSummary <= 1;
      wr(LSPFE_OFF_MACH_STATE, 32'h0000_0800);
      fire(2'h0, 32'h600, 32'h0000_0700, 32'h0, 1, 0);
      rchk("saved", LSPFE_OFF_SAVED_STATE, 32'h0010_0800);
      fpEnabledSummary <= 0;
      {isSprMove, sprSupervisor, sprExternal} <= 3'h7;
      wr(LSPFE_OFF_MACH_STATE, 32'h0002_2000);
      fire(2'h1, 32'h700, 32'h0000_0700, 32'h0, 1, 0);
      rchk("saved", LSPFE_OFF_SAVED_STATE, 32'h0004_2000);
      {isSprMove, sprSupervisor, sprExternal} <= 3'h0;
      for (int i = 0; i < 7; i++) begin
         alignKind <= ak[i];
         alignOp <= ao[i];
         alignUpdate <= au[i];
         alignFault <= 1;
         @(posedge clk);
         alignFault <= 0;
         rchk("align", LSPFE_OFF_ALIGN_CAUSE, {15'h0, ac[i], 10'h0});
      end
      rchk("unmapped", 8'h20, 32'h0);
      chk("slverr", {30'h0, resp}, 32'h2);
      close_out();
   end
endmodule
